// >>> rtl/ctm_pkg.sv
package ctm_pkg;

  // ****************************************************************
  // register map (byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam logic [7:0] REG_CONTROL_ZERO = 8'h00;
  localparam logic [7:0] REG_CONTROL_ONE  = 8'h04;
  localparam logic [7:0] REG_COUNT_LOW    = 8'h08;
  localparam logic [7:0] REG_COUNT_HIGH   = 8'h0C;
  localparam logic [7:0] REG_CMPA_LOW     = 8'h10;
  localparam logic [7:0] REG_CMPA_HIGH    = 8'h14;
  localparam logic [7:0] REG_STATUS       = 8'h18;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int RUN_POS    = 3;
  localparam int COARSE_POS = 0;
  localparam int SWAP_POS   = 1;
  localparam int CLRSEL_POS = 0;
  localparam int INV_POS    = 2;
  localparam int INIT_POS   = 3;
  localparam int OFUNC_POS  = 4;
  localparam int MODE_POS   = 6;

  // ****************************************************************
  // reset values and limits
  // ****************************************************************
  localparam logic [7:0] CONTROL_ZERO_RST = 8'h00;
  localparam logic [7:0] CONTROL_ONE_RST  = 8'h00;
  localparam logic [9:0] FINE_RST         = 10'h000;
  localparam logic [9:0] COUNT_MAX        = 10'h3FF;
  localparam int         CNT_W            = 10;

  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_UNDEF   = 2'b01,
    MODE_PWM     = 2'b10,
    MODE_TIMER   = 2'b11
  } ctm_mode_t;

  typedef enum logic [1:0] {
    OF_HOLD   = 2'b00,
    OF_LOW    = 2'b01,
    OF_HIGH   = 2'b10,
    OF_TOGGLE = 2'b11
  } ctm_ofunc_t;

  // control register one as a packed carrier
  typedef struct packed {
    ctm_mode_t  mode;
    ctm_ofunc_t ofunc;
    logic       initLevel;
    logic       invert;
    logic       swap;
    logic       clearSelect;
  } ctm_ctrl_t;

  // match events of one counting step
  typedef struct packed {
    logic matchA;
    logic matchP;
  } ctm_match_t;

endpackage

// >>> rtl/ctm_compact_timer.sv
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module ctm_compact_timer #(
  parameter int PRESCALE = 4 // timer tick every PRESCALE clocks
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             timerOut,
  output logic             timerOutEn,
  output logic             matchAPulse,
  output logic             matchPPulse
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]            ctrlZero_ff;
  ctm_pkg::ctm_ctrl_t    ctrl_ff;
  logic [9:0]            fine_ff;
  logic [9:0]            count_ff;
  logic [9:0]            nxt_count;
  logic                  runPrev_ff;
  logic                  pinLevel_ff;
  logic                  nxt_pinLevel;
  logic                  flagA_ff;
  logic                  flagP_ff;
  logic [7:0]            preCnt_ff;
  logic                  awHeld_ff;
  logic [7:0]            awAddr_ff;
  logic                  wHeld_ff;
  logic [31:0]           wData_ff;
  logic [3:0]            wStrb_ff;
  logic                  bValid_ff;
  logic [1:0]            bResp_ff;
  logic                  rValid_ff;
  logic [31:0]           rData_ff;
  logic [1:0]            rResp_ff;
  logic                  out_ff;
  logic                  outEn_ff;
  logic                  aPulse_ff;
  logic                  pPulse_ff;

  // ****************************************************************
  // decode of control fields
  // ****************************************************************
  wire logic       run       = ctrlZero_ff[ctm_pkg::RUN_POS];
  wire logic [2:0] coarse    = ctrlZero_ff[ctm_pkg::COARSE_POS +: 3];
  wire logic       runRise   = run & ~runPrev_ff;
  wire logic       isPwm     = (ctrl_ff.mode == ctm_pkg::MODE_PWM);
  wire logic       isCompare = (ctrl_ff.mode == ctm_pkg::MODE_COMPARE);
  wire logic       isTimer   = (ctrl_ff.mode == ctm_pkg::MODE_TIMER);
  wire logic       tick      = run & ~runRise & (preCnt_ff == 8'(PRESCALE - 1));

  // ****************************************************************
  // comparators
  // ****************************************************************
  // coarse meets only the top three counter bits, so its matches fall on 128-tick steps
  // coarse top bits
  wire logic [2:0] pTop   = coarse - 3'h1;                      // top bits in the last step before P
  wire logic       pMatch = (coarse != 3'h0) && (count_ff[9:7] == pTop) && (count_ff[6:0] == 7'h7F);
  wire logic       aMatch = (fine_ff != 10'h000) && (count_ff == fine_ff - 10'h001);
  wire logic       atMax  = (count_ff == ctm_pkg::COUNT_MAX);

  // compare and timer modes choose the clear source
  // clear on A or on P as clearSelect picks, or on overflow when that compare is zero
  wire logic cmpClear = ctrl_ff.clearSelect ? (aMatch | (fine_ff == 10'h000 & atMax))
                                            : (pMatch | (coarse == 3'h0 & atMax));
  wire logic cmpFlagA = aMatch;
  wire logic cmpFlagP = ~ctrl_ff.clearSelect & (pMatch | (coarse == 3'h0 & atMax));

  wire logic pwmClear = ctrl_ff.swap ? (aMatch | (fine_ff == 10'h000 & atMax))
                                     : (pMatch | (coarse == 3'h0 & atMax));

  wire logic pwmFlagA = aMatch | (fine_ff == 10'h000 & atMax);
  wire logic pwmFlagP = pMatch | (coarse == 3'h0 & atMax);

  wire logic doClear = isPwm ? pwmClear : cmpClear;
  wire logic evA     = tick & (isPwm ? pwmFlagA : cmpFlagA);
  wire logic evP     = tick & (isPwm ? pwmFlagP : cmpFlagP);

  // ****************************************************************
  // pwm waveform, evaluated on the current count
  // ****************************************************************
  // duty and period lengths in ticks; zero codes stand for the full 1024, except fine as duty, which stays 0
  wire logic [10:0] coarseLen = (coarse == 3'h0) ? 11'h400 : {1'b0, coarse, 7'h00};
  wire logic [10:0] fineLen   = (fine_ff == 10'h000) ? 11'h400 : {1'b0, fine_ff};
  wire logic [10:0] dutyLen   = ctrl_ff.swap ? coarseLen : {1'b0, fine_ff};
  wire logic [10:0] perLen    = ctrl_ff.swap ? fineLen : coarseLen;
  wire logic        pwmActive = (dutyLen >= perLen) | ({1'b0, count_ff} < dutyLen);
  wire logic        pwmWave   = ~(pwmActive ^ ctrl_ff.initLevel);
  wire logic        pwmPin    = (ctrl_ff.ofunc == ctm_pkg::OF_HIGH) ? pwmWave
                              : (ctrl_ff.ofunc == ctm_pkg::OF_LOW) ? ctrl_ff.initLevel
                              : ~ctrl_ff.initLevel;

  // ****************************************************************
  // counter next value
  // ****************************************************************
  // restart on run rising, hold when stopped
  // pwm counts regardless of pin force
  always_comb begin
    nxt_count = count_ff;
    if (runRise) begin
      nxt_count = 10'h000;
    end else if (tick) begin
      nxt_count = doClear ? 10'h000 : count_ff + 10'h001;
    end
  end

  // ****************************************************************
  // compare mode pin level
  // ****************************************************************
  // initial level on run rising
  // only A match moves the pin
  always_comb begin
    nxt_pinLevel = pinLevel_ff;
    if (runRise) begin
      nxt_pinLevel = ctrl_ff.initLevel;
    end else if (evA && isCompare) begin
      case (ctrl_ff.ofunc)
        ctm_pkg::OF_LOW:    nxt_pinLevel = 1'b0;
        ctm_pkg::OF_HIGH:   nxt_pinLevel = 1'b1;
        ctm_pkg::OF_TOGGLE: nxt_pinLevel = ~pinLevel_ff;
        default:            nxt_pinLevel = pinLevel_ff;
      endcase
    end
  end

  // ****************************************************************
  // timer core state
  // ****************************************************************
  // prescaler only runs with the counter so a restart lines up ticks
  always_ff @(posedge clock) begin
    if (!rstn) begin
      preCnt_ff   <= 8'h00;
      runPrev_ff  <= 1'b0;
      count_ff    <= 10'h000;
      pinLevel_ff <= 1'b0;
    end else begin
      preCnt_ff   <= (!run || runRise || tick) ? 8'h00 : preCnt_ff + 8'h01;
      runPrev_ff  <= run;
      count_ff    <= nxt_count;
      pinLevel_ff <= nxt_pinLevel;
    end
  end

  // pin driver: compare drives latched level, pwm the waveform, timer releases pin
  // compare drives pin
  always_ff @(posedge clock) begin
    if (!rstn) begin
      out_ff    <= 1'b0;
      outEn_ff  <= 1'b0;
      aPulse_ff <= 1'b0;
      pPulse_ff <= 1'b0;
    end else begin
      out_ff    <= (isPwm ? pwmPin : nxt_pinLevel) ^ ctrl_ff.invert;
      outEn_ff  <= ~isTimer & (ctrl_ff.mode != ctm_pkg::MODE_UNDEF);
      aPulse_ff <= evA;
      pPulse_ff <= evP;
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  wire logic doWrite = awHeld_ff & wHeld_ff & ~bValid_ff;
  wire logic doRead  = s_axi_arvalid & ~rValid_ff;
  wire logic wrHit   = (awAddr_ff == ctm_pkg::REG_CONTROL_ZERO) | (awAddr_ff == ctm_pkg::REG_CONTROL_ONE)
                     | (awAddr_ff == ctm_pkg::REG_CMPA_LOW) | (awAddr_ff == ctm_pkg::REG_CMPA_HIGH)
                     | (awAddr_ff == ctm_pkg::REG_STATUS) | (awAddr_ff == ctm_pkg::REG_COUNT_LOW)
                     | (awAddr_ff == ctm_pkg::REG_COUNT_HIGH);
  wire logic wrLane  = doWrite & wStrb_ff[0];

  // read mux; counter is read-only, status is write-one-to-clear
  // high byte upper bits zero
  wire logic [7:0] rdByte =
      (s_axi_araddr == ctm_pkg::REG_CONTROL_ZERO) ? ctrlZero_ff :
      (s_axi_araddr == ctm_pkg::REG_CONTROL_ONE)  ? ctrl_ff :
      (s_axi_araddr == ctm_pkg::REG_COUNT_LOW)    ? count_ff[7:0] :
      (s_axi_araddr == ctm_pkg::REG_COUNT_HIGH)   ? {6'h00, count_ff[9:8]} :
      (s_axi_araddr == ctm_pkg::REG_CMPA_LOW)     ? fine_ff[7:0] :
      (s_axi_araddr == ctm_pkg::REG_CMPA_HIGH)    ? {6'h00, fine_ff[9:8]} :
      (s_axi_araddr == ctm_pkg::REG_STATUS)       ? {6'h00, flagP_ff, flagA_ff} : 8'h00;
  wire logic rdHit = (s_axi_araddr == ctm_pkg::REG_CONTROL_ZERO) | (s_axi_araddr == ctm_pkg::REG_CONTROL_ONE)
                   | (s_axi_araddr == ctm_pkg::REG_COUNT_LOW) | (s_axi_araddr == ctm_pkg::REG_COUNT_HIGH)
                   | (s_axi_araddr == ctm_pkg::REG_CMPA_LOW) | (s_axi_araddr == ctm_pkg::REG_CMPA_HIGH)
                   | (s_axi_araddr == ctm_pkg::REG_STATUS);

  // address and data are caught independently, in either order
  always_ff @(posedge clock) begin
    if (!rstn) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= 8'h00;
      wHeld_ff  <= 1'b0;
      wData_ff  <= 32'h0000_0000;
      wStrb_ff  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !awHeld_ff) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_ff <= 1'b0;
      end
      if (s_axi_wvalid && !wHeld_ff) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_ff <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer SLVERR
  always_ff @(posedge clock) begin
    if (!rstn) begin
      bValid_ff <= 1'b0;
      bResp_ff  <= 2'b00;
    end else if (doWrite) begin
      bValid_ff <= 1'b1;
      bResp_ff  <= wrHit ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      bValid_ff <= 1'b0;
    end
  end

  // software-written registers; writes to read-only words are dropped
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrlZero_ff <= ctm_pkg::CONTROL_ZERO_RST;
      ctrl_ff     <= ctm_pkg::CONTROL_ONE_RST;
      fine_ff     <= ctm_pkg::FINE_RST;
    end else if (wrLane) begin
      if (awAddr_ff == ctm_pkg::REG_CONTROL_ZERO) begin
        ctrlZero_ff <= {4'h0, wData_ff[ctm_pkg::RUN_POS], wData_ff[2:0]};
      end
      if (awAddr_ff == ctm_pkg::REG_CONTROL_ONE) begin
        ctrl_ff <= wData_ff[7:0];
      end
      if (awAddr_ff == ctm_pkg::REG_CMPA_LOW) begin
        fine_ff[7:0] <= wData_ff[7:0];
      end
      if (awAddr_ff == ctm_pkg::REG_CMPA_HIGH) begin
        fine_ff[9:8] <= wData_ff[1:0];
      end
    end
  end

  // sticky match flags; write one to clear, a new event wins over the clear
  wire logic clrFlags = wrLane & (awAddr_ff == ctm_pkg::REG_STATUS);
  always_ff @(posedge clock) begin
    if (!rstn) begin
      flagA_ff <= 1'b0;
      flagP_ff <= 1'b0;
    end else begin
      flagA_ff <= evA | (flagA_ff & ~(clrFlags & wData_ff[0]));
      flagP_ff <= evP | (flagP_ff & ~(clrFlags & wData_ff[1]));
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rValid_ff <= 1'b0;
      rData_ff  <= 32'h0000_0000;
      rResp_ff  <= 2'b00;
    end else if (doRead) begin
      rValid_ff <= 1'b1;
      rData_ff  <= {24'h00_0000, rdByte};
      rResp_ff  <= rdHit ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      rValid_ff <= 1'b0;
    end
  end

  assign s_axi_awready = ~awHeld_ff;
  assign s_axi_wready  = ~wHeld_ff;
  assign s_axi_bvalid  = bValid_ff;
  assign s_axi_bresp   = bResp_ff;
  assign s_axi_arready = ~rValid_ff;
  assign s_axi_rvalid  = rValid_ff;
  assign s_axi_rdata   = rData_ff;
  assign s_axi_rresp   = rResp_ff;
  assign timerOut      = out_ff;
  assign timerOutEn    = outEn_ff;
  assign matchAPulse   = aPulse_ff;
  assign matchPPulse   = pPulse_ff;

endmodule // ctm_compact_timer

`default_nettype wire

// >>> bench/ctm_timer_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// port checker for the compact timer
// ****************************************
module ctm_timer_checker #(
  parameter int PRESCALE = 4
) (
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        timerOut,
  input wire logic        timerOutEn,
  input wire logic        matchAPulse,
  input wire logic        matchPPulse
);
  logic [7:0]         addr_ff;
  logic [7:0]         data_ff;
  logic               strobe_ff;
  logic               bvPrev_ff;
  logic               run_ff;
  logic [2:0]         age_ff;
  ctm_pkg::ctm_ctrl_t ctrl_ff;
  // a write lands when bvalid rises; shadows lag the design by one clock
  wire doWrite = s_axi_bvalid && !bvPrev_ff && strobe_ff;
  wire steady  = (age_ff == 3'h7);
  wire isCmp   = (ctrl_ff.mode == ctm_pkg::MODE_COMPARE);
  wire noPin   = (ctrl_ff.mode == ctm_pkg::MODE_TIMER);
  // shadow of run and control one; age hides the settling after each write
  always_ff @(posedge clock) begin
    bvPrev_ff <= s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) addr_ff <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) data_ff <= s_axi_wdata[7:0];
    if (s_axi_wvalid && s_axi_wready) strobe_ff <= s_axi_wstrb[0];
    age_ff <= doWrite ? 3'h0 : (steady ? age_ff : age_ff + 3'h1);
    if (doWrite && addr_ff == ctm_pkg::REG_CONTROL_ZERO) run_ff <= data_ff[ctm_pkg::RUN_POS];
    if (doWrite && addr_ff == ctm_pkg::REG_CONTROL_ONE) ctrl_ff <= data_ff;
    if (!rstn) begin
      run_ff <= 1'b0;
      ctrl_ff <= 8'h00;
      age_ff <= 3'h0;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_a_single: assert property (PRESCALE > 1 && matchAPulse |=> !matchAPulse)
    else $error("match A pulse longer than one clock");
  a_p_single: assert property (PRESCALE > 1 && matchPPulse |=> !matchPPulse)
    else $error("match P pulse longer than one clock");
  a_timer_pin_off: assert property (steady && noPin |-> !timerOutEn)
    else $error("pin driven in timer mode");
  a_pin_driven: assert property (steady && (isCmp || ctrl_ff.mode == ctm_pkg::MODE_PWM) |-> timerOutEn)
    else $error("pin not driven in compare or pwm mode");
  a_clra_no_p: assert property (steady && (isCmp || noPin) && ctrl_ff.clearSelect |-> !matchPPulse)
    else $error("P flag with clear on A");
  a_pin_a_only: assert property (steady && run_ff && isCmp && $changed(timerOut) |-> matchAPulse)
    else $error("pin moved without an A match");
  a_a_toggle: assert property (steady && isCmp && ctrl_ff.ofunc == ctm_pkg::OF_TOGGLE && matchAPulse
    |-> timerOut != $past(timerOut)) else $error("pin did not toggle on A match");
  a_hold_pin: assert property (steady && isCmp && ctrl_ff.ofunc == ctm_pkg::OF_HOLD |-> $stable(timerOut))
    else $error("pin moved with function hold");
  a_run_init: assert property ($rose(run_ff) && isCmp && !ctrl_ff.invert
    |-> ##[0:4] timerOut == ctrl_ff.initLevel) else $error("pin not at initial level after start");
  a_stop_quiet: assert property (!run_ff [*4] |-> !matchAPulse && !matchPPulse)
    else $error("match while stopped");
endmodule // ctm_timer_checker
bind ctm_compact_timer ctm_timer_checker #(.PRESCALE(PRESCALE)) chk (
  .clock(clock), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .timerOut(timerOut), .timerOutEn(timerOutEn), .matchAPulse(matchAPulse), .matchPPulse(matchPPulse));
`default_nettype wire

// >>> bench/ctm_pin_load.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// external load on the timer pin
// ****************************************
module ctm_pin_load (
  input wire logic   clock,
  input wire logic   timerOut,
  input wire logic   timerOutEn,
  output logic       lineLevel,
  output logic [15:0] highLen,
  output logic [15:0] periodLen
);
  logic [15:0] high_ff;
  logic [15:0] period_ff;
  logic        prev_ff;
  // a released pin falls to the pull-down of the load
  assign lineLevel = timerOutEn ? timerOut : 1'b0;
  // measure high time and rise-to-rise period in clocks
  always_ff @(posedge clock) begin
    prev_ff <= lineLevel;
    period_ff <= (lineLevel && !prev_ff) ? 16'h0001 : period_ff + 16'h0001;
    high_ff <= (lineLevel && !prev_ff) ? 16'h0001 : high_ff + {15'h0000, lineLevel};
    if (lineLevel && !prev_ff) periodLen <= period_ff;
    if (!lineLevel && prev_ff) highLen <= high_ff;
  end
endmodule // ctm_pin_load
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int PS = 2;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  awAddr = 8'h00;
  logic [7:0]  arAddr = 8'h00;
  logic [31:0] wData = 32'h00000000;
  logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic        awReady, wReady, bValid, arReady, rValid, pinOut, pinEn, pulseA, pulseP, lineLevel;
  logic [1:0]  bResp, rResp, rsp;
  logic [31:0] rData, va, vb;
  logic [15:0] highLen, periodLen;
  int          fail_count = 0, num_checks = 0, n, bad;
  logic [7:0]  regs [7] = '{ctm_pkg::REG_CONTROL_ZERO, ctm_pkg::REG_CONTROL_ONE, ctm_pkg::REG_COUNT_LOW,
    ctm_pkg::REG_COUNT_HIGH, ctm_pkg::REG_CMPA_LOW, ctm_pkg::REG_CMPA_HIGH, ctm_pkg::REG_STATUS};
  // pwm cases: control one, fine, coarse, high ticks, period ticks
  logic [7:0]  pC1 [4] = '{8'hA8, 8'hAA, 8'hAC, 8'hA0};
  logic [9:0]  pFine [4] = '{10'h020, 10'h12C, 10'h020, 10'h040};
  logic [2:0]  pCrs [4] = '{3'h1, 3'h1, 3'h2, 3'h1};
  int          pHigh [4] = '{32, 128, 224, 64};
  int          pPer [4] = '{128, 300, 256, 128};
  always #10 clock = ~clock;
  ctm_compact_timer #(.PRESCALE(PS)) dut (
    .clock(clock), .rstn(rstn), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .timerOut(pinOut), .timerOutEn(pinEn),
    .matchAPulse(pulseA), .matchPPulse(pulseP));
  ctm_pin_load load (.clock(clock), .timerOut(pinOut), .timerOutEn(pinEn), .lineLevel(lineLevel),
    .highLen(highLen), .periodLen(periodLen));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // each channel is released at the edge that takes it; an edge passes before a new request
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    @(posedge clock);
    awAddr <= a;
    wData <= {24'h000000, d};
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clock);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
    end while (bValid !== 1'b1);
    resp = bResp;
    bReady <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clock);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clock);
      if (arValid && arReady) arValid <= 1'b0;
    end while (rValid !== 1'b1);
    d = rData;
    resp = rResp;
    rReady <= 1'b0;
  endtask
  // stop, configure, then start: mode and function only change while stopped
  task automatic cfg(input logic [7:0] c1, input logic [9:0] fine, input logic [2:0] crs);
    wr(ctm_pkg::REG_CONTROL_ZERO, {5'h00, crs}, rsp);
    wr(ctm_pkg::REG_CONTROL_ONE, c1, rsp);
    wr(ctm_pkg::REG_CMPA_LOW, fine[7:0], rsp);
    wr(ctm_pkg::REG_CMPA_HIGH, {6'h00, fine[9:8]}, rsp);
    wr(ctm_pkg::REG_CONTROL_ZERO, {5'h01, crs}, rsp);
  endtask
  // clocks until the next pulse, bounded by the watchdog
  task automatic gap(input logic useP, output int cnt);
    cnt = 0;
    do begin
      @(posedge clock);
      cnt++;
    end while ((useP ? pulseP : pulseA) !== 1'b1);
  endtask
  task automatic hold(input logic lvl, output int cnt);
    cnt = 0;
    repeat (300) begin
      @(posedge clock);
      if (lineLevel !== lvl) cnt++;
    end
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    // ****************************************
    // reset values, unmapped and narrow registers
    // ****************************************
    foreach (regs[i]) begin
      rd(regs[i], va, rsp);
      check(va, 32'h00000000);
    end
    rd(8'h1C, va, rsp);
    check(va, 32'h00000000);
    check(32'(rsp), 32'h00000002);
    wr(8'h1C, 8'h5A, rsp);
    check(32'(rsp), 32'h00000002);
    wr(ctm_pkg::REG_CMPA_HIGH, 8'hFF, rsp);
    rd(ctm_pkg::REG_CMPA_HIGH, va, rsp);
    check(va, 32'h00000003);
    // ****************************************
    // compare mode, clear on A, every pin function
    // ****************************************
    for (int f = 0; f < 4; f++) begin
      cfg({2'h0, 2'(f), (f != 2), 3'h1}, 10'h014, 3'h0);
      repeat (3) @(posedge clock);
      check(32'(lineLevel), 32'(f != 2));
      gap(1'b0, n);
      check(32'(lineLevel), 32'((f == 0) || (f == 2)));
      gap(1'b0, n);
      check(n, 20 * PS);
    end
    // clear on P with coarse one, then overflow with coarse zero
    cfg(8'h00, 10'h014, 3'h1);
    gap(1'b1, n);
    gap(1'b1, n);
    check(n, 128 * PS);
    gap(1'b0, n);
    check(n, 20 * PS);
    wr(ctm_pkg::REG_CONTROL_ZERO, 8'h01, rsp);
    rd(ctm_pkg::REG_COUNT_LOW, va, rsp);
    repeat (20) @(posedge clock);
    rd(ctm_pkg::REG_COUNT_LOW, vb, rsp);
    check(vb, va);
    rd(ctm_pkg::REG_STATUS, va, rsp);
    check(va, 32'h00000003);
    wr(ctm_pkg::REG_STATUS, 8'h03, rsp);
    rd(ctm_pkg::REG_STATUS, va, rsp);
    check(va, 32'h00000000);
    cfg(8'h00, 10'h014, 3'h0);
    gap(1'b1, n);
    gap(1'b1, n);
    check(n, 1024 * PS);
    // clear on A with fine zero: overflow at 3FF and no A flag
    cfg(8'h31, 10'h000, 3'h0);
    bad = 0;
    repeat (2200) begin
      @(posedge clock);
      if (pulseA !== 1'b0) bad++;
    end
    check(bad, 0);
    // timer mode: same counting, pin released
    cfg(8'hF9, 10'h014, 3'h0);
    gap(1'b0, n);
    gap(1'b0, n);
    check(n, 20 * PS);
    check(32'({pinEn, lineLevel}), 32'h00000000);
    // the undefined mode code leaves the pin released as well
    cfg(8'h40, 10'h014, 3'h0);
    repeat (3) @(posedge clock);
    check(32'({pinEn, lineLevel}), 32'h00000000);
    // ****************************************
    // pwm: period, duty, swap, polarity, flags
    // ****************************************
    for (int k = 0; k < 4; k++) begin
      cfg(pC1[k], pFine[k], pCrs[k]);
      gap(1'b0, n);
      gap(1'b0, n);
      check(n, pPer[k] * PS);
      gap(1'b1, n);
      gap(1'b1, n);
      check(n, pPer[k] * PS);
      check({highLen, periodLen}, {16'(pHigh[k] * PS), 16'(pPer[k] * PS)});
    end
    cfg(8'hA8, 10'h0C8, 3'h1);
    hold(1'b1, bad);
    check(bad, 0);
    cfg(8'h88, 10'h020, 3'h1);
    hold(1'b0, bad);
    check(bad, 0);
    gap(1'b0, n);
    gap(1'b0, n);
    check(n, 128 * PS);
    cfg(8'h98, 10'h020, 3'h1);
    hold(1'b1, bad);
    check(bad, 0);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
